// ==== rtl/pvic_pkg.sv ====
package pvic_pkg;
  localparam logic [7:0] CMD_TURNOFF = 8'h36;
  localparam logic [7:0] CMD_PLACE = 8'h37;
  localparam logic [7:0] CMD_GAIN = 8'h38;
  localparam logic [7:0] CMD_OFFSET = 8'h39;
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam logic [4:0] TURNOFF_EXP_RST = 5'h1E;
  localparam logic [4:0] GAIN_EXP_RST = 5'h19;
  localparam logic [4:0] OFFSET_EXP_RST = 5'h1C;
  // Thresholds in quarter volts: 2.25 V to 18.25 V.
  localparam int THR_FRAC = 2;
  localparam int THR_MIN = 9;
  localparam int THR_MAX = 73;
  // Gain in 1/1024 units during checks, in 1/128 units after restore.
  localparam int GAIN_FRAC = 10;
  localparam int GAIN_MAX = 2032;
  localparam logic [10:0] GAIN_CAP_MAN = 11'h0FE;
  // Current in 1/16 A units.
  localparam int OFF_FRAC = 4;
  localparam int OFF_LIMIT = 512;
  localparam int PL_GROUP_LSB = 8;
  localparam int PL_COUNT_LSB = 4;
  localparam int PL_ORDER_LSB = 0;
  localparam int PL_COUNT_MAX = 4;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SW_PERIOD_NS = 2000;
  localparam int SW_PERIOD_CYC = SW_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] phase;
    logic [15:0] data;
  } pvic_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } pvic_rsp_t;

  // Linear word to fixed point with frac fraction bits; right shifts floor.
  function automatic logic signed [31:0] lin_fix(input logic [15:0] w,
                                                input int frac);
    logic signed [31:0] m;
    int e;
    m = 32'(signed'(w[MAN_MSB:0]));
    e = int'(signed'(w[15:EXP_LSB])) + frac;
    if (e >= 0) lin_fix = m <<< e;
    else lin_fix = m >>> (-e);
  endfunction : lin_fix
endpackage : pvic_pkg

// ==== rtl/pvic_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module pvic_regs #(
  parameter int NUM_PHASE = 4,
  parameter int PERIOD_CYC = pvic_pkg::SW_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire pvic_pkg::pvic_cmd_t cmd,
  output pvic_pkg::pvic_rsp_t rsp,
  input wire logic [10:0] nvmTurnoffMantissa,
  input wire logic [3:0] nvmGroupNumber,
  input wire logic [3:0] nvmGroupCount,
  input wire logic [3:0] nvmSlotOrder,
  input wire logic [10:0] nvmGainTrimMantissa,
  input wire logic [10:0] nvmOffsetTrimMantissa,
  input wire logic makerCommandStack,
  input wire logic restoreAll,
  input wire logic [2:0] stackPhases,
  input wire logic [7:0] powerInputVoltage,
  input wire logic enableMet,
  input wire logic clearStatus,
  input wire logic signed [15:0] senseCurrent,
  input wire logic syncIn,
  output logic [15:0] reportCurrent,
  output logic [15:0] stackOffsetSum,
  output logic conversionOn,
  output logic lowInputOff,
  output logic invalidData,
  output logic placementWritable,
  output logic oscStart
);
  import pvic_pkg::*;

  logic powerLoad_q;
  logic [15:0] thrWord_q, thrWord_d;
  logic [11:0] plWord_q, plWord_d;
  logic [15:0] gainWord_q, gainWord_d;
  logic [15:0] offWord_q [NUM_PHASE];
  logic [15:0] offWord_d [NUM_PHASE];
  logic writable_q, writable_d;
  logic invalid_q, invalid_d;
  logic lowIn_q, lowIn_d;
  logic convOn_q, convOn_d;
  pvic_rsp_t rsp_q, rsp_d;
  logic [15:0] report_q, report_d;
  logic [15:0] offSum_q, offSum_d;
  logic loadReq, badWrite, readCmd, writeCmd, below;
  logic signed [31:0] thrFix, valFix, offAcc;
  logic signed [47:0] gainProd;
  logic [3:0] nPh;
  logic signed [15:0] allProd;
  logic [7:0] appliedThr;

  function automatic logic [10:0] gain_round(input logic [10:0] m);
    logic [11:0] r;
    r = {1'b0, m} + 12'h001;
    r[0] = 1'b0;
    if (m[10]) gain_round = 11'h000;
    else if (r > {1'b0, GAIN_CAP_MAN}) gain_round = GAIN_CAP_MAN;
    else gain_round = r[10:0];
  endfunction : gain_round

  function automatic logic place_ok(input logic [11:0] w);
    logic [3:0] c;
    c = w[PL_COUNT_LSB +: 4];
    place_ok = (c >= 4'h1) && (int'(c) <= PL_COUNT_MAX) &&
               (w[PL_ORDER_LSB +: 4] < c);
  endfunction : place_ok

  assign loadReq = powerLoad_q | restoreAll;
  assign readCmd = cmd.valid & ~cmd.write;
  assign writeCmd = cmd.valid & cmd.write & ~loadReq;
  assign nPh = (stackPhases == 3'h0) ? 4'h1 :
               (int'(stackPhases) > NUM_PHASE) ? 4'(NUM_PHASE) :
               {1'b0, stackPhases};

  // Floor to a quarter-volt step, clamped to the hardware span.
  always_comb begin
    thrFix = lin_fix(thrWord_q, THR_FRAC);
    if (thrFix < THR_MIN) appliedThr = 8'(THR_MIN);
    else if (thrFix > THR_MAX) appliedThr = 8'(THR_MAX);
    else appliedThr = thrFix[7:0];
  end

  always_comb begin
    thrWord_d = thrWord_q;
    plWord_d = plWord_q;
    gainWord_d = gainWord_q;
    offWord_d = offWord_q;
    writable_d = writable_q;
    rsp_d = '0;
    badWrite = 1'b0;
    valFix = '0;
    allProd = '0;
    if (powerLoad_q) begin
      writable_d = ~makerCommandStack;
    end
    if (loadReq) begin
      thrWord_d = {TURNOFF_EXP_RST, nvmTurnoffMantissa};
      plWord_d = {nvmGroupNumber, nvmGroupCount, nvmSlotOrder};
      gainWord_d = {GAIN_EXP_RST, gain_round(nvmGainTrimMantissa)};
      for (int i = 0; i < NUM_PHASE; i++) begin
        offWord_d[i] = {OFFSET_EXP_RST, nvmOffsetTrimMantissa};
      end
    end else if (writeCmd) begin
      unique case (cmd.code)
        CMD_TURNOFF: begin
          valFix = lin_fix(cmd.data, THR_FRAC);
          if (valFix < THR_MIN || valFix > THR_MAX) badWrite = 1'b1;
          else thrWord_d = cmd.data;
        end
        CMD_PLACE: begin
          // A stack member must not move its phase slot.
          if (!writable_q || !place_ok(cmd.data[11:0])) badWrite = 1'b1;
          else plWord_d = cmd.data[11:0];
        end
        CMD_GAIN: begin
          valFix = lin_fix(cmd.data, GAIN_FRAC);
          if (valFix < 0 || valFix > GAIN_MAX) badWrite = 1'b1;
          else gainWord_d = cmd.data;
        end
        CMD_OFFSET: begin
          valFix = lin_fix(cmd.data, OFF_FRAC);
          if (valFix < -OFF_LIMIT || valFix > OFF_LIMIT) begin
            badWrite = 1'b1;
          end else if (cmd.phase == PHASE_ALL) begin
            for (int i = 0; i < NUM_PHASE; i++) begin
              offWord_d[i] = {cmd.data[15:EXP_LSB],
                11'($signed(cmd.data[10:0]) / $signed({1'b0, nPh}))};
            end
          end else if (cmd.phase < 8'(NUM_PHASE)) begin
            offWord_d[cmd.phase[1:0]] = cmd.data;
          end else begin
            badWrite = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (readCmd) begin
      rsp_d.valid = 1'b1;
      unique case (cmd.code)
        CMD_TURNOFF: rsp_d.data = thrWord_q;
        CMD_PLACE: rsp_d.data = {4'h0, plWord_q};
        CMD_GAIN: rsp_d.data = gainWord_q;
        CMD_OFFSET: begin
          if (cmd.phase == PHASE_ALL) begin
            allProd = 16'($signed(offWord_q[0][10:0]) *
                          $signed({1'b0, nPh}));
            // The product may leave the mantissa range, so it saturates.
            if (allProd > 16'sh03FF) allProd = 16'sh03FF;
            else if (allProd < -16'sh0400) allProd = -16'sh0400;
            rsp_d.data = {offWord_q[0][15:EXP_LSB], allProd[10:0]};
          end else if (cmd.phase < 8'(NUM_PHASE)) begin
            rsp_d.data = offWord_q[cmd.phase[1:0]];
          end
        end
        default: rsp_d.valid = 1'b0;
      endcase
    end
    // A new error in the clearing cycle keeps the flag set.
    invalid_d = (invalid_q & ~clearStatus) | badWrite;
  end

  // Current report and input voltage supervision.
  always_comb begin
    offAcc = '0;
    for (int i = 0; i < NUM_PHASE; i++) begin
      offAcc = offAcc + lin_fix(offWord_q[i], OFF_FRAC);
    end
    offSum_d = offAcc[15:0];
    gainProd = 48'(senseCurrent) * 48'(lin_fix(gainWord_q, GAIN_FRAC));
    report_d = 16'((gainProd >>> GAIN_FRAC) + 48'(offAcc));
    below = powerInputVoltage < appliedThr;
    convOn_d = enableMet & ~below;
    lowIn_d = (lowIn_q & ~clearStatus) | (enableMet & below);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      powerLoad_q <= 1'b1;
      thrWord_q <= {TURNOFF_EXP_RST, 11'h000};
      plWord_q <= 12'h010;
      gainWord_q <= {GAIN_EXP_RST, 11'h080};
      for (int i = 0; i < NUM_PHASE; i++) begin
        offWord_q[i] <= {OFFSET_EXP_RST, 11'h000};
      end
      writable_q <= 1'b0;
      invalid_q <= 1'b0;
      lowIn_q <= 1'b0;
      convOn_q <= 1'b0;
      rsp_q <= '0;
      report_q <= 16'h0000;
      offSum_q <= 16'h0000;
    end else begin
      powerLoad_q <= 1'b0;
      thrWord_q <= thrWord_d;
      plWord_q <= plWord_d;
      gainWord_q <= gainWord_d;
      offWord_q <= offWord_d;
      writable_q <= writable_d;
      invalid_q <= invalid_d;
      lowIn_q <= lowIn_d;
      convOn_q <= convOn_d;
      rsp_q <= rsp_d;
      report_q <= report_d;
      offSum_q <= offSum_d;
    end
  end

  // Phase placement of the switching oscillator against the sync pin.
  logic [2:0] syncSh_q;
  logic syncLvl_q, syncLvl_d, run_q, run_d, osc_q, osc_d, syncEdge;
  logic [15:0] cnt_q, cnt_d, dly;

  always_comb begin
    dly = 16'((PERIOD_CYC * int'(plWord_q[PL_ORDER_LSB +: 4])) /
              ((plWord_q[PL_COUNT_LSB +: 4] == 4'h0) ? 1 :
               int'(plWord_q[PL_COUNT_LSB +: 4])));
    syncEdge = (syncSh_q[1] == syncSh_q[2]) && syncSh_q[2] && !syncLvl_q;
    syncLvl_d = (syncSh_q[1] == syncSh_q[2]) ? syncSh_q[2] : syncLvl_q;
    cnt_d = cnt_q;
    run_d = run_q;
    osc_d = 1'b0;
    if (syncEdge) begin
      cnt_d = 16'h0000;
      run_d = (dly != 16'h0000);
      osc_d = (dly == 16'h0000);
    end else if (run_q) begin
      cnt_d = cnt_q + 16'h0001;
      if (cnt_q + 16'h0001 == dly) begin
        osc_d = 1'b1;
        run_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      syncSh_q <= 3'h0;
      syncLvl_q <= 1'b0;
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      syncSh_q <= {syncSh_q[1:0], syncIn};
      syncLvl_q <= syncLvl_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      osc_q <= osc_d;
    end
  end

  assign rsp = rsp_q;
  assign reportCurrent = report_q;
  assign stackOffsetSum = offSum_q;
  assign conversionOn = convOn_q;
  assign lowInputOff = lowIn_q;
  assign invalidData = invalid_q;
  assign placementWritable = writable_q;
  assign oscStart = osc_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_place_read;
    cmd.valid && !cmd.write && cmd.code == CMD_PLACE;
  endsequence
  sequence s_locked_write;
    writeCmd && cmd.code == CMD_PLACE && !writable_q;
  endsequence

  a_turnoff_exp: assert property (loadReq |=>
    thrWord_q[15:EXP_LSB] == TURNOFF_EXP_RST)
    else $error("Turn-off exponent not restored.");
  a_bad_flag: assert property (writeCmd && cmd.code == CMD_TURNOFF &&
    lin_fix(cmd.data, THR_FRAC) > THR_MAX |=> invalidData && $stable(thrWord_q))
    else $error("Out of range threshold accepted.");
  a_place_zero: assert property (s_place_read |=>
    rsp.valid && rsp.data[15:12] == 4'h0)
    else $error("Placement upper bits not zero.");
  a_place_lock: assert property (s_locked_write |=>
    $stable(plWord_q) && invalidData)
    else $error("Locked placement changed.");
  a_lock_fixed: assert property (!powerLoad_q |=>
    $stable(placementWritable))
    else $error("Writability changed after power-on.");
  a_gain_round: assert property (loadReq |=>
    gainWord_q[10:0] <= GAIN_CAP_MAN && !gainWord_q[0] &&
    gainWord_q[15:EXP_LSB] == GAIN_EXP_RST)
    else $error("Restored gain not rounded.");
  a_low_input: assert property (enableMet &&
    powerInputVoltage < appliedThr |=> lowInputOff && !conversionOn
    ##1 (lowInputOff || $past(clearStatus)))
    else $error("Low input not reported.");
  a_osc_zero: assert property (syncEdge && dly == 16'h0000 |=>
    oscStart)
    else $error("Zero delay start missed.");
  a_osc_span: assert property (run_q && !syncEdge &&
    cnt_q + 16'h0001 == dly |=> oscStart && !run_q)
    else $error("Delayed start missed.");
endmodule : pvic_regs
`default_nettype wire

// ==== tb/pvic_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pvic_host (
  input wire logic clk,
  output pvic_pkg::pvic_cmd_t cmd,
  input wire pvic_pkg::pvic_rsp_t rsp
);
  import pvic_pkg::*;
  initial cmd = '0;
  // One word per call; threshold writes stay below the turn-on level,
  // and placement is also written after a stack power-up, where it is rejected.
  task automatic xfer(input logic w, input logic [7:0] c, p,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    cmd <= '{1'b1, w, c, p, d};
    @(posedge clk);
    // Released data shows its inverse so a stale word is never mistaken.
    cmd <= '{1'b0, w, c, p, ~d};
    q = 16'h0000;
    #1;
    if (rsp.valid === 1'b1) q = rsp.data;
  endtask : xfer
endmodule : pvic_host
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pvic_pkg::*;
  localparam logic [31:0] BAD [8] = '{32'h3600F008, 32'h3600F04A,
    32'h37000250, 32'h37000222, 32'h3800C900, 32'h3800CC00,
    32'h3905E010, 32'h39000021};
  logic clk = 1'b0;
  logic rst = 1'b1;
  pvic_cmd_t cmd;
  pvic_rsp_t rsp;
  logic [10:0] nvmTo = 11'h028;
  logic [10:0] nvmGa = 11'h080;
  logic stk = 1'b0;
  logic restoreAll = 1'b0;
  logic enableMet = 1'b0;
  logic clearStatus = 1'b0;
  logic syncIn = 1'b0;
  logic [2:0] stackPhases = 3'h4;
  logic [7:0] pv = 8'h00;
  logic signed [15:0] sense = 16'sh0010;
  logic [15:0] rep, sum;
  logic convOn, lowOff, inv, plWr, osc;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  pvic_host u_host (.clk(clk), .cmd(cmd), .rsp(rsp));
  pvic_regs #(.PERIOD_CYC(16)) u_dut (.clk(clk), .rst(rst), .cmd(cmd),
    .rsp(rsp), .nvmTurnoffMantissa(nvmTo), .nvmGroupNumber(4'h2),
    .nvmGroupCount(4'h4), .nvmSlotOrder(4'h1),
    .nvmGainTrimMantissa(nvmGa), .nvmOffsetTrimMantissa(11'h000),
    .makerCommandStack(stk), .restoreAll(restoreAll),
    .stackPhases(stackPhases), .powerInputVoltage(pv),
    .enableMet(enableMet), .clearStatus(clearStatus),
    .senseCurrent(sense), .syncIn(syncIn), .reportCurrent(rep),
    .stackOffsetSum(sum), .conversionOn(convOn), .lowInputOff(lowOff),
    .invalidData(inv), .placementWritable(plWr), .oscStart(osc));
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // The whole run needs well under 5000 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_rst(input logic s);
    @(posedge clk);
    rst <= 1'b1;
    stk <= s;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_rst
  task automatic wr(input logic [7:0] c, p, input logic [15:0] d);
    logic [15:0] q;
    @(posedge clk);
    clearStatus <= 1'b1;
    @(posedge clk);
    clearStatus <= 1'b0;
    u_host.xfer(1'b1, c, p, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] c, p, input logic [15:0] e);
    logic [15:0] q;
    u_host.xfer(1'b0, c, p, 16'h0000, q);
    chk(q, e);
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic lat(output int n);
    repeat (40) @(posedge clk);
    syncIn <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (osc !== 1'b1 && n < 80);
    @(posedge clk);
    syncIn <= 1'b0;
  endtask : lat
  task automatic t_reset();
    rd(CMD_TURNOFF, 8'h00, 16'hF028);
    rd(CMD_PLACE, 8'h00, 16'h0241);
    rd(CMD_GAIN, 8'h00, 16'hC880);
    rd(CMD_OFFSET, 8'h00, 16'hE000);
    chk(rep, 16'h0010);
    chk({15'h0, plWr}, 16'h0001);
    $display("done reset");
  endtask : t_reset
  task automatic t_invalid();
    logic [15:0] q0, q1;
    for (int i = 0; i < 8; i++) begin
      u_host.xfer(1'b0, BAD[i][31:24], BAD[i][23:16], 16'h0000, q0);
      wr(BAD[i][31:24], BAD[i][23:16], BAD[i][15:0]);
      chk({15'h0, inv}, 16'h0001);
      u_host.xfer(1'b0, BAD[i][31:24], BAD[i][23:16], 16'h0000, q1);
      chk(q1, q0);
    end
    $display("done invalid");
  endtask : t_invalid
  task automatic t_thresh();
    @(posedge clk);
    enableMet <= 1'b1;
    pv <= 8'h08;
    wr(CMD_TURNOFF, 8'h00, 16'hF009);
    chk({15'h0, inv}, 16'h0000);
    rd(CMD_TURNOFF, 8'h00, 16'hF009);
    settle();
    chk({14'h0, convOn, lowOff}, 16'h0001);
    // 2.375 V must floor to 2.25 V, so a 2.25 V input turns conversion on.
    wr(CMD_TURNOFF, 8'h00, 16'hE813);
    @(posedge clk);
    pv <= 8'h09;
    settle();
    chk({14'h0, convOn, lowOff}, 16'h0003);
    wr(CMD_TURNOFF, 8'h00, 16'hF049);
    settle();
    chk({14'h0, inv, convOn}, 16'h0000);
    $display("done threshold");
  endtask : t_thresh
  task automatic t_place();
    int a, b;
    wr(CMD_PLACE, 8'h00, 16'h0320);
    rd(CMD_PLACE, 8'h00, 16'h0320);
    lat(a);
    wr(CMD_PLACE, 8'h00, 16'hF321);
    rd(CMD_PLACE, 8'h00, 16'h0321);
    lat(b);
    chk(16'(b - a), 16'h0008);
    $display("done placement");
  endtask : t_place
  task automatic t_trim();
    wr(CMD_GAIN, 8'h00, 16'hC8C0);
    wr(CMD_OFFSET, 8'h01, 16'hE010);
    settle();
    chk(sum, 16'h0010);
    chk(rep, 16'h0028);
    wr(CMD_OFFSET, PHASE_ALL, 16'hE040);
    rd(CMD_OFFSET, 8'h02, 16'hE010);
    rd(CMD_OFFSET, PHASE_ALL, 16'hE040);
    settle();
    chk(rep, 16'h0058);
    // A negative phase offset must pull the report down.
    wr(CMD_OFFSET, 8'h03, 16'hE7F0);
    settle();
    chk(sum, 16'h0020);
    chk(rep, 16'h0038);
    @(posedge clk);
    stackPhases <= 3'h0;
    rd(CMD_OFFSET, PHASE_ALL, 16'hE010);
    $display("done trim");
  endtask : t_trim
  task automatic t_restore();
    logic [10:0] m [2] = '{11'h0FF, 11'h081};
    logic [15:0] e [2] = '{16'hC8FE, 16'hC882};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      nvmGa <= m[i];
      restoreAll <= 1'b1;
      @(posedge clk);
      restoreAll <= 1'b0;
      rd(CMD_GAIN, 8'h00, e[i]);
    end
    rd(CMD_TURNOFF, 8'h00, 16'hF028);
    $display("done restore");
  endtask : t_restore
  task automatic t_lock();
    do_rst(1'b1);
    chk({15'h0, plWr}, 16'h0000);
    wr(CMD_PLACE, 8'h00, 16'h0320);
    chk({15'h0, inv}, 16'h0001);
    rd(CMD_PLACE, 8'h00, 16'h0241);
    @(posedge clk);
    stk <= 1'b0;
    settle();
    chk({15'h0, plWr}, 16'h0000);
    $display("done lock");
  endtask : t_lock
  initial begin
    do_rst(1'b0);
    t_reset();
    t_invalid();
    t_thresh();
    t_place();
    t_trim();
    t_restore();
    t_lock();
    results();
  end
endmodule : tb
`default_nettype wire
